// File: src/mbwr_crc.sv
`timescale 1ns/1ps
// One CRC-16 byte step, reflected polynomial, no state of its own
module mbwr_crc (
  // Running value
  input wire logic [15:0] crc_i,
  // New byte
  input wire logic [7:0] byte_i,
  // Updated value
  output logic [15:0] crc_o
);

  // Eight shift steps unrolled by a loop
  always_comb begin
    logic [15:0] c;
    c = crc_i ^ {8'h00, byte_i};
    for (int k = 0; k < 8; k++) begin
      if (c[0]) begin
        c = (c >> 1) ^ mbwr_pkg::CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_o = c;
  end

endmodule

// File: src/mbwr_pkg.sv
package mbwr_pkg;

  // ------------------------------------------------------------------
  // Frame fields
  // ------------------------------------------------------------------
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FC_EXCEPTION_BIT = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] MAX_REGS = 16'h0010;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // ------------------------------------------------------------------
  // Register offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] ADDR_GROUP_UPPER = 16'h0030;
  localparam logic [15:0] ADDR_GROUP_LOWER = 16'h0031;
  localparam logic [15:0] ADDR_INCMD_UPPER = 16'h007c;
  localparam logic [15:0] ADDR_INCMD_LOWER = 16'h007d;
  localparam logic [15:0] ADDR_OUTST_UPPER = 16'h007e;
  localparam logic [15:0] ADDR_OUTST_LOWER = 16'h007f;
  localparam logic [31:0] GROUP_RESET = 32'hffffffff;
  localparam logic [31:0] INCMD_RESET = 32'h00000000;
  localparam logic [31:0] GROUP_MIN = 32'h00000001;
  localparam logic [31:0] GROUP_MAX = 32'h0000001f;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    MBWR_IDLE = 4'h0,
    MBWR_HDR = 4'h1,
    MBWR_DATA = 4'h2,
    MBWR_CRC = 4'h3,
    MBWR_SKIP = 4'h4,
    MBWR_CHECK = 4'h5,
    MBWR_COMMIT = 4'h6,
    MBWR_REPLY = 4'h7,
    MBWR_DONE = 4'h8
  } mbwr_state_e;

  // Byte stream carrier
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mbwr_byte_s;

  // Whole state of the frame engine
  typedef struct packed {
    mbwr_state_e state;
    logic [4:0] idx;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0] bytes;
    logic [15:0] crc_rx;
    logic [7:0] func;
    logic [7:0] slave;
    logic group_hit;
    logic [15:0][15:0] buf_data;
    logic [31:0] group;
    logic [31:0] incmd;
    logic [15:0] upper_hold;
    logic upper_ok;
    logic [7:0] exc;
    logic [3:0] tx_idx;
    logic [3:0] tx_len;
    logic [15:0] tx_crc;
    mbwr_byte_s tx;
    logic frame_err;
  } mbwr_state_s;

endpackage

// File: src/mbwr_regs.sv
`timescale 1ns/1ps
module mbwr_regs #(
  parameter int MAX_WORDS = 16
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  // Own slave address and decoded frame boundary
  input wire logic [7:0] SLAVE_ADDR_I,
  input wire logic FRAME_END_I,
  // Received bytes from the serial receiver
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  // Transmit byte stream towards the serial sender
  input wire logic TX_READY_I,
  output logic TX_VALID_O,
  output logic [7:0] TX_DATA_O,
  // Driver command and status
  input wire logic [31:0] OUT_STATUS_I,
  output logic [31:0] IN_COMMAND_O,
  output logic [31:0] GROUP_ADDR_O
);

  // ------------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  logic [8:0] rx_meta;
  logic [8:0] rx_sync;
  logic fe_meta;
  logic fe_sync;
  logic tx_rdy_meta;
  logic tx_rdy_sync;

  // Reset asserts at once, releases two edges later
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Receiver and sender live outside this clock; sample twice
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 9'h000;
      rx_sync <= 9'h000;
      fe_meta <= 1'b0;
      fe_sync <= 1'b0;
      tx_rdy_meta <= 1'b0;
      tx_rdy_sync <= 1'b0;
    end else begin
      rx_meta <= {RX_VALID_I, RX_DATA_I};
      rx_sync <= rx_meta;
      fe_meta <= FRAME_END_I;
      fe_sync <= fe_meta;
      tx_rdy_meta <= TX_READY_I;
      tx_rdy_sync <= tx_rdy_meta;
    end
  end

  // Byte strobe is a level per byte; take its rising edge only
  logic rx_valid_d;
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid_d <= 1'b0;
    end else begin
      rx_valid_d <= rx_sync[8];
    end
  end

  mbwr_pkg::mbwr_byte_s rx;
  assign rx.valid = rx_sync[8] && !rx_valid_d;
  assign rx.data = rx_sync[7:0];

  // ------------------------------------------------------------------
  // CRC steps for receive and transmit
  // ------------------------------------------------------------------
  mbwr_pkg::mbwr_state_s s;
  mbwr_pkg::mbwr_state_s next_s;
  logic [15:0] rx_crc_next;
  logic [15:0] tx_crc_next;
  logic [7:0] tx_byte;

  mbwr_crc u_rx_crc (
    .crc_i(s.crc_rx),
    .byte_i(rx.data),
    .crc_o(rx_crc_next)
  );

  mbwr_crc u_tx_crc (
    .crc_i(s.tx_crc),
    .byte_i(tx_byte),
    .crc_o(tx_crc_next)
  );

  // ------------------------------------------------------------------
  // Reply byte selection
  // ------------------------------------------------------------------
  // echo of header
  always_comb begin
    tx_byte = 8'h00;
    case (s.tx_idx)
      4'h0: tx_byte = s.slave;
      4'h1: tx_byte = (s.exc != 8'h00) ? (s.func | mbwr_pkg::FC_EXCEPTION_BIT) : s.func;
      4'h2: tx_byte = (s.exc != 8'h00) ? s.exc : s.start[15:8];
      4'h3: tx_byte = s.start[7:0];
      4'h4: tx_byte = s.count[15:8];
      4'h5: tx_byte = s.count[7:0];
      default: tx_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------------
  logic [15:0] cur_addr;
  logic [15:0] cur_word;
  assign cur_addr = s.start + {11'h000, s.idx};
  assign cur_word = s.buf_data[s.idx[3:0]];

  always_comb begin
    logic [31:0] grp_val;
    grp_val = {s.upper_hold, cur_word};
    next_s = s;
    next_s.tx.valid = 1'b0;
    case (s.state)
      mbwr_pkg::MBWR_IDLE: begin
        if (rx.valid) begin
          next_s.crc_rx = rx_crc_next;
          next_s.slave = rx.data;
          next_s.group_hit = (s.group != mbwr_pkg::GROUP_RESET) &&
                             (rx.data == s.group[7:0]);
          next_s.idx = 5'h00;
          next_s.frame_err = 1'b0;
          next_s.exc = 8'h00;
          next_s.upper_ok = 1'b0;
          if (rx.data == SLAVE_ADDR_I || next_s.group_hit) begin
            next_s.state = mbwr_pkg::MBWR_HDR;
          end else begin
            next_s.state = mbwr_pkg::MBWR_SKIP;
          end
        end
      end
      mbwr_pkg::MBWR_HDR: begin
        if (rx.valid) begin
          next_s.crc_rx = rx_crc_next;
          next_s.idx = s.idx + 5'h01;
          case (s.idx)
            5'h00: next_s.func = rx.data;
            5'h01: next_s.start[15:8] = rx.data;
            5'h02: next_s.start[7:0] = rx.data;
            5'h03: next_s.count[15:8] = rx.data;
            5'h04: next_s.count[7:0] = rx.data;
            default: next_s.bytes = rx.data;
          endcase
          if (s.idx == 5'h00 && rx.data != mbwr_pkg::FC_WRITE_MULTI) begin
            next_s.state = mbwr_pkg::MBWR_SKIP;
          end
          if (s.idx == 5'h05) begin
            next_s.idx = 5'h00;
            if (s.count == 16'h0000 || s.count > mbwr_pkg::MAX_REGS ||
                {8'h00, rx.data} != {s.count[14:0], 1'b0}) begin
              next_s.exc = mbwr_pkg::EXC_ILLEGAL_VALUE;
              next_s.bytes = 8'h00;
              next_s.state = mbwr_pkg::MBWR_CRC;
            end else begin
              next_s.state = mbwr_pkg::MBWR_DATA;
            end
          end
        end
      end
      mbwr_pkg::MBWR_DATA: begin
        if (rx.valid) begin
          next_s.crc_rx = rx_crc_next;
          next_s.bytes = s.bytes - 8'h01;
          if (s.idx[0] == 1'b0) begin
            next_s.buf_data[s.idx[4:1]][15:8] = rx.data;
          end else begin
            next_s.buf_data[s.idx[4:1]][7:0] = rx.data;
          end
          next_s.idx = s.idx + 5'h01;
          if (s.bytes == 8'h01) begin
            next_s.idx = 5'h00;
            next_s.state = mbwr_pkg::MBWR_CRC;
          end
        end
      end
      mbwr_pkg::MBWR_CRC: begin
        if (rx.valid) begin
          next_s.crc_rx = rx_crc_next;
          next_s.idx = s.idx + 5'h01;
          if (s.idx == 5'h01 && s.exc == 8'h00) begin
            next_s.idx = 5'h00;
            next_s.state = mbwr_pkg::MBWR_CHECK;
          end
        end
        if (fe_sync) begin // Refused header swallows the rest, judged at the gap
          next_s.state = (s.exc != 8'h00) ? mbwr_pkg::MBWR_CHECK : mbwr_pkg::MBWR_IDLE;
        end
      end
      // Residue of zero means the whole frame checked out
      mbwr_pkg::MBWR_CHECK: begin
        if (s.crc_rx != 16'h0000) begin
          next_s.state = mbwr_pkg::MBWR_SKIP;
        end else if (s.exc != 8'h00) begin
          next_s.state = mbwr_pkg::MBWR_REPLY;
        end else begin
          next_s.state = mbwr_pkg::MBWR_COMMIT;
        end
      end
      mbwr_pkg::MBWR_COMMIT: begin
        next_s.idx = s.idx + 5'h01;
        case (cur_addr)
          mbwr_pkg::ADDR_GROUP_UPPER,
          mbwr_pkg::ADDR_INCMD_UPPER: begin
            next_s.upper_hold = cur_word;
            next_s.upper_ok = 1'b1;
          end
          mbwr_pkg::ADDR_GROUP_LOWER: begin
            if (s.upper_ok && (grp_val == mbwr_pkg::GROUP_RESET ||
                (grp_val >= mbwr_pkg::GROUP_MIN && grp_val <= mbwr_pkg::GROUP_MAX))) begin
              next_s.group = grp_val;
            end else begin
              next_s.exc = mbwr_pkg::EXC_ILLEGAL_VALUE;
            end
            next_s.upper_ok = 1'b0;
          end
          mbwr_pkg::ADDR_INCMD_LOWER: begin
            if (s.upper_ok) begin
              next_s.incmd = {s.upper_hold, cur_word};
            end else begin
              next_s.exc = mbwr_pkg::EXC_ILLEGAL_VALUE;
            end
            next_s.upper_ok = 1'b0;
          end
          default: begin
            next_s.exc = mbwr_pkg::EXC_ILLEGAL_ADDR;
          end
        endcase
        if ({11'h000, s.idx} == s.count - 16'h0001) begin
          next_s.state = mbwr_pkg::MBWR_REPLY;
        end
        if (next_s.exc != 8'h00) begin
          next_s.state = mbwr_pkg::MBWR_REPLY;
        end
      end
      // Prepare reply; group queries get no reply, only our own address is answered
      mbwr_pkg::MBWR_REPLY: begin
        next_s.tx_idx = 4'h0;
        next_s.tx_crc = mbwr_pkg::CRC_INIT;
        next_s.tx_len = (s.exc != 8'h00) ? 4'h5 : 4'h8;
        if (s.slave != SLAVE_ADDR_I) begin
          next_s.state = mbwr_pkg::MBWR_SKIP;
        end else begin
          next_s.state = mbwr_pkg::MBWR_DONE;
        end
      end
      // Stream the reply while the sender is ready
      mbwr_pkg::MBWR_DONE: begin
        if (tx_rdy_sync && !s.tx.valid) begin
          next_s.tx.valid = 1'b1;
          next_s.tx_idx = s.tx_idx + 4'h1;
          if (s.tx_idx == s.tx_len - 4'h2) begin
            next_s.tx.data = s.tx_crc[7:0];
          end else if (s.tx_idx == s.tx_len - 4'h1) begin
            next_s.tx.data = s.tx_crc[15:8];
            next_s.state = mbwr_pkg::MBWR_SKIP;
          end else begin
            next_s.tx.data = tx_byte;
            next_s.tx_crc = tx_crc_next;
          end
        end
      end
      // Wait for the frame gap before the next query
      mbwr_pkg::MBWR_SKIP: begin
        if (fe_sync) begin
          next_s.state = mbwr_pkg::MBWR_IDLE;
          next_s.crc_rx = mbwr_pkg::CRC_INIT;
        end
      end
      default: next_s.state = mbwr_pkg::MBWR_IDLE;
    endcase
    if (s.state == mbwr_pkg::MBWR_IDLE && !rx.valid) begin
      next_s.crc_rx = mbwr_pkg::CRC_INIT;
    end
    if (fe_sync && (s.state == mbwr_pkg::MBWR_HDR || s.state == mbwr_pkg::MBWR_DATA)) begin
      next_s.state = mbwr_pkg::MBWR_IDLE; // Cut query dropped at the gap
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // volatile storage only
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.state <= mbwr_pkg::MBWR_IDLE;
      s.crc_rx <= mbwr_pkg::CRC_INIT;
      s.tx_crc <= mbwr_pkg::CRC_INIT;
      s.group <= mbwr_pkg::GROUP_RESET;
      s.incmd <= mbwr_pkg::INCMD_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Status input is sampled twice; it comes from driver logic elsewhere
  logic [31:0] status_meta;
  logic [31:0] status_sync;
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      status_meta <= 32'h00000000;
      status_sync <= 32'h00000000;
    end else begin
      status_meta <= OUT_STATUS_I;
      status_sync <= status_meta;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ------------------------------------------------------------------
  assign TX_VALID_O = s.tx.valid;
  assign TX_DATA_O = s.tx.data;
  assign IN_COMMAND_O = s.incmd;
  assign GROUP_ADDR_O = s.group;

endmodule

// File: verif/mbwr_master_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Serial master seen as a byte stream
// ------------------------------------------------------------------
module mbwr_master_model (
  // Clock
  input wire logic clk_i,
  // Query stream
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic frame_end_o,
  // Reply stream
  output logic tx_ready_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i
);
  logic [7:0] rq[$];
  logic slow = 1'b0;
  logic [2:0] k = 3'h0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    frame_end_o = 1'b1;
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Field order, check low byte first
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    rq.delete();
    @(negedge clk_i);
    frame_end_o <= 1'b0;
    foreach (b[i]) begin
      rx_data_o <= b[i];
      rx_valid_o <= 1'b1;
      repeat (4) @(negedge clk_i);
      rx_valid_o <= 1'b0;
      // Released data shows junk, not the last byte
      rx_data_o <= ~b[i];
      repeat (4) @(negedge clk_i);
    end
    frame_end_o <= 1'b1;
  endtask

  // Ready stalls three quarters of the time when slow
  always @(negedge clk_i) begin
    k <= k + 3'h1;
    tx_ready_o <= !slow || k[2:1] == 2'b00;
    if (tx_valid_i) begin
      rq.push_back(tx_data_i);
    end
  end
endmodule

// File: verif/mbwr_regs_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port checker for the write engine
// ------------------------------------------------------------------
module mbwr_regs_asserts #(
  parameter int MAX_WORDS = 16
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  // Link side
  input wire logic [7:0] SLAVE_ADDR_I,
  input wire logic FRAME_END_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic TX_READY_I,
  input wire logic TX_VALID_O,
  input wire logic [7:0] TX_DATA_O,
  // Driver side
  input wire logic [31:0] OUT_STATUS_I,
  input wire logic [31:0] IN_COMMAND_O,
  input wire logic [31:0] GROUP_ADDR_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // Reply bytes since the last query byte, saturating
  logic [3:0] tx_n;
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_n <= 4'h0;
    end else if (RX_VALID_I) begin
      tx_n <= 4'h0;
    end else if (TX_VALID_O && tx_n != 4'hf) begin
      tx_n <= tx_n + 4'h1;
    end
  end

  // Reply byte is followed by a quiet cycle
  sequence s_gap;
    !TX_VALID_O;
  endsequence
  property p_rst_vals;
    $rose(ARST_N_I) |-> !TX_VALID_O && IN_COMMAND_O == 32'h00000000
      && GROUP_ADDR_O == mbwr_pkg::GROUP_RESET;
  endproperty
  property p_grp_range;
    GROUP_ADDR_O == 32'hffffffff || (GROUP_ADDR_O >= 32'h00000001
      && GROUP_ADDR_O <= 32'h0000001f);
  endproperty
  property p_tx_pulse;
    TX_VALID_O |=> s_gap;
  endproperty
  property p_tx_ready;
    TX_VALID_O |-> $past(TX_READY_I, 2) || $past(TX_READY_I, 3) || $past(TX_READY_I, 4);
  endproperty
  property p_tx_hold;
    $changed(TX_DATA_O) |-> TX_VALID_O;
  endproperty
  property p_rep_addr;
    TX_VALID_O && tx_n == 4'h0 |-> TX_DATA_O == SLAVE_ADDR_I;
  endproperty
  property p_rep_func;
    TX_VALID_O && tx_n == 4'h1 |-> TX_DATA_O == 8'h10 || TX_DATA_O == 8'h90;
  endproperty
  property p_rep_len;
    TX_VALID_O |-> tx_n < 4'h8;
  endproperty
  property p_cmd_commit;
    $changed(IN_COMMAND_O) |-> tx_n == 4'h0;
  endproperty
  property p_grp_commit;
    $changed(GROUP_ADDR_O) |-> tx_n == 4'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("Outputs off reset value");
  a_grp_range: assert property (p_grp_range) else $error("Group out of range");
  a_tx_pulse: assert property (p_tx_pulse) else $error("Reply strobe too long");
  a_tx_ready: assert property (p_tx_ready) else $error("Reply byte without ready");
  a_tx_hold: assert property (p_tx_hold) else $error("Reply data moved alone");
  a_rep_addr: assert property (p_rep_addr) else $error("Reply address wrong");
  a_rep_func: assert property (p_rep_func) else $error("Reply function wrong");
  a_rep_len: assert property (p_rep_len) else $error("Reply too long");
  a_cmd_commit: assert property (p_cmd_commit) else $error("Command moved in reply");
  a_grp_commit: assert property (p_grp_commit) else $error("Group moved in reply");
endmodule

bind mbwr_regs mbwr_regs_asserts #(.MAX_WORDS(MAX_WORDS)) u_chk (
  .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .SLAVE_ADDR_I(SLAVE_ADDR_I),
  .FRAME_END_I(FRAME_END_I), .RX_VALID_I(RX_VALID_I), .RX_DATA_I(RX_DATA_I),
  .TX_READY_I(TX_READY_I), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O),
  .OUT_STATUS_I(OUT_STATUS_I), .IN_COMMAND_O(IN_COMMAND_O), .GROUP_ADDR_O(GROUP_ADDR_O));

// File: verif/test_modbus_multi_write_opcmd_regs.sv
`timescale 1ns/1ps
module test_modbus_multi_write_opcmd_regs;
  // ------------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------------
  localparam logic [7:0] SA = 8'h11;
  localparam int LIMIT = 40000;
  typedef struct {
    logic [15:0] st;
    logic [7:0] cnt;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [7:0] ex;
    logic [31:0] grp;
    logic [31:0] cmd;
  } mbwr_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxv, fe, txr, txv;
  logic [7:0] rxd, txd;
  logic [31:0] cmd, grp;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] q[$];
  logic [7:0] e[$];
  logic [15:0] wv[0:16];
  mbwr_row_s rows[7] = '{
    '{16'h0030, 8'h02, 16'h0000, 16'h0005, 8'h00, 32'h00000005, 32'h00000000},
    '{16'h007c, 8'h02, 16'h1234, 16'habcd, 8'h00, 32'h00000005, 32'h1234abcd},
    '{16'h0030, 8'h02, 16'h0000, 16'h0020, 8'h03, 32'h00000005, 32'h1234abcd},
    '{16'h007e, 8'h02, 16'h0001, 16'h0002, 8'h02, 32'h00000005, 32'h1234abcd},
    '{16'h0030, 8'h02, 16'h0000, 16'h001f, 8'h00, 32'h0000001f, 32'h1234abcd},
    '{16'h0031, 8'h01, 16'h0005, 16'h0000, 8'h03, 32'h0000001f, 32'h1234abcd},
    '{16'h0030, 8'h02, 16'hffff, 16'hffff, 8'h00, 32'hffffffff, 32'h1234abcd}
  };
  always #4 clk = ~clk;

  mbwr_regs DUT (.REF_CLK_I(clk), .ARST_N_I(rst_n), .SLAVE_ADDR_I(SA), .FRAME_END_I(fe),
    .RX_VALID_I(rxv), .RX_DATA_I(rxd), .TX_READY_I(txr), .TX_VALID_O(txv), .TX_DATA_O(txd),
    .OUT_STATUS_I(32'h5a5a0f0f), .IN_COMMAND_O(cmd), .GROUP_ADDR_O(grp));
  mbwr_master_model M (.clk_i(clk), .rx_valid_o(rxv), .rx_data_o(rxd), .frame_end_o(fe),
    .tx_ready_o(txr), .tx_valid_i(txv), .tx_data_i(txd));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write query; silent when not our address or check corrupted
  task automatic query(input logic [7:0] sa, input logic [15:0] st, input logic [7:0] cnt,
      input logic [7:0] bc, input int nw, input logic [7:0] ex, input logic bad);
    logic [15:0] c;
    int t;
    q = {sa, 8'h10, st[15:8], st[7:0], 8'h00, cnt, bc};
    for (int i = 0; i < nw; i++) begin
      q.push_back(wv[i][15:8]);
      q.push_back(wv[i][7:0]);
    end
    e.delete();
    if (sa == SA && !bad) begin
      if (ex == 8'h00) begin
        e = {sa, 8'h10, st[15:8], st[7:0], 8'h00, cnt};
      end else begin
        e = {sa, 8'h90, ex};
      end
      c = M.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    M.send(q, bad);
    t = 0;
    while (M.rq.size() < e.size() && t < 800) begin
      @(negedge clk);
      t++;
    end
    repeat (40) @(negedge clk);
    chk(M.rq.size(), e.size());
    foreach (e[i]) chk(M.rq[i], e[i]);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    foreach (rows[i]) begin
      wv[0] = rows[i].w0;
      wv[1] = rows[i].w1;
      query(SA, rows[i].st, rows[i].cnt, {rows[i].cnt[6:0], 1'b0}, rows[i].cnt, rows[i].ex,
        1'b0);
      chk(grp, rows[i].grp);
      chk(cmd, rows[i].cmd);
    end
    // Seventeen registers refused whole
    foreach (wv[i]) wv[i] = 16'h00ee;
    query(SA, 16'h007c, 8'h11, 8'h22, 17, 8'h03, 1'b0);
    chk(cmd, 32'h1234abcd);
    // Byte count not twice the count
    query(SA, 16'h007c, 8'h02, 8'h02, 1, 8'h03, 1'b0);
    chk(cmd, 32'h1234abcd);
    // Pair committed before the unmapped register stops the run, reply stalled
    wv[0] = 16'h0000;
    wv[1] = 16'h0007;
    wv[2] = 16'h0000;
    wv[3] = 16'h0000;
    M.slow = 1'b1;
    query(SA, 16'h0030, 8'h04, 8'h08, 4, 8'h02, 1'b0);
    M.slow = 1'b0;
    chk(grp, 32'h00000007);
    // Corrupted check is ignored
    wv[1] = 16'h0001;
    query(SA, 16'h007c, 8'h02, 8'h04, 2, 8'h00, 1'b1);
    chk(cmd, 32'h1234abcd);
    // Another slave's query is ignored; an empty count is refused
    query(8'h22, 16'h007c, 8'h02, 8'h04, 2, 8'h00, 1'b0);
    chk(cmd, 32'h1234abcd);
    query(SA, 16'h007c, 8'h00, 8'h00, 0, 8'h03, 1'b0);
    chk(cmd, 32'h1234abcd);
    // Query to the group address is taken silently
    wv[1] = 16'h0042;
    query(8'h07, 16'h007c, 8'h02, 8'h04, 2, 8'h00, 1'b0);
    chk(cmd, 32'h00000042);
    // Reset in mid-run restores the volatile registers
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(grp, 32'hffffffff);
    chk(cmd, 32'h00000000);
    test_done();
  end
endmodule
